// file: shared/cbt_pkg.sv
package cbt_pkg;

   // Field widths of the timing configuration, then the counter width; every field holds its value minus one.
   localparam int BRP_W   = 6;
   localparam int TSEG1_W = 4;
   localparam int TSEG2_W = 3;
   localparam int SJW_W   = 2;
   localparam int CNT_W   = 5;

   // Bus levels.
   localparam logic RECESSIVE = 1'b1;
   localparam logic DOMINANT  = 1'b0;

   // Reset values and the counter increment.
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [BRP_W-1:0] BRP_ZERO = 6'h00;
   localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;

   // Bit timing phases, counted from one sample point to the next.
   typedef enum logic [1:0]
   {
      PH_SYNC  = 2'b00,
      PH_TSEG1 = 2'b01,
      PH_TSEG2 = 2'b11
   } cbt_phase_type;

   typedef struct packed
   {
      logic [BRP_W-1:0]   brp;
      logic [TSEG1_W-1:0] tseg1;
      logic [TSEG2_W-1:0] tseg2;
      logic [SJW_W-1:0]   sjw;
   } cbt_cfg_type;

   typedef struct packed
   {
      logic sample_point;
      logic rx_bit;
      logic hard_sync;
      logic resync;
   } cbt_evt_type;

   // Turns a programmed field into its functional length in quanta.
   function automatic logic [CNT_W-1:0] cbt_plus_one(input logic [CNT_W-1:0] field);
      return field + CNT_ONE;
   endfunction

   // Limits a phase error magnitude to the jump width.
   function automatic logic [CNT_W-1:0] cbt_limit(input logic [CNT_W-1:0] err,
                                                  input logic [CNT_W-1:0] sjw_len);
      return (err < sjw_len) ? err : sjw_len;
   endfunction

endpackage

// file: design/cbt_tq_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module cbt_tq_prescaler
   import cbt_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_n_i,
   // Control
   input  wire logic              run_i,
   input  wire logic [BRP_W-1:0]  brp_i,
   // Quantum strobe
   output logic                   tick_o
);

   typedef struct packed
   {
      logic [BRP_W-1:0] cnt;
      logic             tick;
   } cbt_psc_state_type;

   cbt_psc_state_type q;
   cbt_psc_state_type d;

   // The divider is held at zero while stopped so that the first quantum is a full one.
   always_comb
   begin
      d      = q;
      d.tick = 1'b0;
      if (!run_i)
      begin
         d.cnt = BRP_ZERO;
      end
      else if (q.cnt >= brp_i)
      begin
         d.cnt  = BRP_ZERO;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + 6'h01;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tick_o = q.tick;

endmodule

`default_nettype wire

// file: design/cbt_bit_timing.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Only recessive-to-dominant edges synchronise
// - Edge: previous sample recessive, quantum dominant
// - Phase error measured from end of sync, or to start of next sync for early edges
// - Hard sync at frame start, else resync
// - Hard sync restarts bit after sync
// - Late edge lengthens segment one, limited
// - Early edge shortens segment two, limited
// - Fully corrected early edge also skips next sync
// - One synchronisation between two sample points
// - Segment changes last for current bit
// - Bit counted from sample point onward
// - Covered spike moves sample past it
// - Sync segment fixed at one quantum
// - Jump width 1-4, segment one 1-16, segment two 1-8
// - Fields hold value minus one
// - No processing time after sample point
module cbt_bit_timing
   import cbt_pkg::*;
(
   // Clock and reset
   input  wire logic         ref_clk_i,
   input  wire logic         rst_n_i,
   // Configuration and control from the protocol engine
   input  wire logic         run_i,
   input  wire logic         hard_sync_en_i,
   input  wire cbt_cfg_type  cfg_i,
   // Receive pin from the transceiver
   input  wire logic         rx_i,
   // Timing events
   output cbt_evt_type       evt_o
);

   typedef struct packed
   {
      logic              rx_meta;
      logic              rx_sync;
      cbt_phase_type     phase;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  len1;
      logic [CNT_W-1:0]  len2;
      logic              samp;
      logic              synced;
      cbt_evt_type       evt;
   } cbt_btl_state_type;

   cbt_btl_state_type q;
   cbt_btl_state_type d;

   logic             tick;
   logic [CNT_W-1:0] nom1;
   logic [CNT_W-1:0] nom2;
   logic [CNT_W-1:0] sjw_len;
   logic             edge_seen;
   logic [CNT_W-1:0] err;
   logic [CNT_W-1:0] eff1;
   logic [CNT_W-1:0] eff2;

   cbt_tq_prescaler u_prescaler
   (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .run_i     (run_i),
      .brp_i     (cfg_i.brp),
      .tick_o    (tick)
   );

   assign nom1    = cbt_plus_one({1'b0, cfg_i.tseg1});
   assign nom2    = cbt_plus_one({2'b00, cfg_i.tseg2});
   assign sjw_len = cbt_plus_one({3'b000, cfg_i.sjw});

   assign edge_seen = (q.samp == RECESSIVE) && (q.rx_sync == DOMINANT) && !q.synced;

   always_comb
   begin
      d                  = q;
      d.rx_meta          = rx_i;
      d.rx_sync          = q.rx_meta;
      d.evt.sample_point = 1'b0;
      d.evt.hard_sync    = 1'b0;
      d.evt.resync       = 1'b0;
      err                = CNT_ZERO;
      eff1               = q.len1;
      eff2               = q.len2;
      if (!run_i)
      begin
         // Stopped: wait in sync with the bus taken as idle.
         d.phase  = PH_SYNC;
         d.cnt    = CNT_ZERO;
         d.len1   = nom1;
         d.len2   = nom2;
         d.samp   = RECESSIVE;
         d.synced = 1'b0;
      end
      else if (tick)
      begin
         if (edge_seen && hard_sync_en_i)
         begin
            // hard restart
            // The edge quantum becomes the sync segment, the next quantum starts segment one.
            d.phase         = PH_TSEG1;
            d.cnt           = CNT_ZERO;
            d.len1          = nom1;
            d.len2          = nom2;
            d.synced        = 1'b1;
            d.evt.hard_sync = 1'b1;
         end
         else
         begin
            unique case (q.phase)
               PH_SYNC:
               begin
                  // single quantum
                  // An edge here is synchronous and needs no correction.
                  d.phase = PH_TSEG1;
                  d.cnt   = CNT_ZERO;
                  if (edge_seen)
                  begin
                     d.synced = 1'b1;
                  end
               end
               PH_TSEG1:
               begin
                  if (edge_seen)
                  begin
                     err = q.cnt + CNT_ONE;
                     eff1         = q.len1 + cbt_limit(err, sjw_len);
                     d.len1       = eff1;
                     d.synced     = 1'b1;
                     d.evt.resync = 1'b1;
                  end
                  if (q.cnt + CNT_ONE >= eff1)
                  begin
                     d.samp             = q.rx_sync;
                     d.evt.rx_bit       = q.rx_sync;
                     d.evt.sample_point = 1'b1;
                     d.phase            = PH_TSEG2;
                     d.cnt              = CNT_ZERO;
                     d.synced           = 1'b0;
                     d.len1             = nom1;
                     d.len2             = nom2;
                  end
                  else
                  begin
                     d.cnt = q.cnt + CNT_ONE;
                  end
               end
               PH_TSEG2:
               begin
                  if (edge_seen)
                  begin
                     err = q.len2 - q.cnt;
                     eff2         = q.len2 - cbt_limit(err, sjw_len);
                     d.len2       = eff2;
                     d.synced     = 1'b1;
                     d.evt.resync = 1'b1;
                     // skip sync
                     // Shortening may reach zero; the edge quantum stands in for the sync segment.
                     // A partial correction ends segment two normally and keeps the sync quantum.
                     if (eff2 <= q.cnt)
                     begin
                        d.phase = PH_TSEG1;
                        d.cnt   = CNT_ZERO;
                     end
                     else if (q.cnt + CNT_ONE >= eff2)
                     begin
                        d.phase = PH_SYNC;
                        d.cnt   = CNT_ZERO;
                     end
                     else
                     begin
                        d.cnt = q.cnt + CNT_ONE;
                     end
                  end
                  else if (q.cnt + CNT_ONE >= q.len2)
                  begin
                     d.phase = PH_SYNC;
                     d.cnt   = CNT_ZERO;
                  end
                  else
                  begin
                     d.cnt = q.cnt + CNT_ONE;
                  end
               end
               default:
               begin
                  d.phase = PH_SYNC;
                  d.cnt   = CNT_ZERO;
               end
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q            <= '0;
         q.rx_meta    <= RECESSIVE;
         q.rx_sync    <= RECESSIVE;
         q.phase      <= PH_SYNC;
         q.samp       <= RECESSIVE;
         q.evt.rx_bit <= RECESSIVE;
      end
      else
      begin
         q <= d;
      end
   end

   assign evt_o = q.evt;

   // Checks below watch this block's state together with run_i, hard_sync_en_i and the configuration.
   logic [1:0] syncs_q;

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         syncs_q <= 2'h0;
      end
      else if (q.evt.sample_point || !run_i)
      begin
         syncs_q <= 2'h0;
      end
      else if ((q.evt.hard_sync || q.evt.resync) && syncs_q != 2'h3)
      begin
         syncs_q <= syncs_q + 2'h1;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking

   default disable iff (!rst_n_i);

   AST_RISE_ONLY: assert property (tick && run_i && q.samp == DOMINANT |=> !q.evt.resync && !q.evt.hard_sync)
      else $error("Synchronised after a dominant sample point.");

   AST_ONE_SYNC: assert property (syncs_q <= 2'h1)
      else $error("More than one synchronisation between sample points.");

   AST_HARD_GATED: assert property (q.evt.hard_sync |-> $past(hard_sync_en_i) && !q.evt.resync)
      else $error("Hard synchronisation outside frame start.");

   AST_HARD_RESTART: assert property (q.evt.hard_sync |-> q.phase == PH_TSEG1 && q.cnt == CNT_ZERO)
      else $error("Hard synchronisation did not restart the bit.");

   AST_SYNC_ONE_TQ: assert property (tick && run_i && q.phase == PH_SYNC |=> q.phase == PH_TSEG1)
      else $error("Sync segment longer than one quantum.");

   AST_EXT_BOUND: assert property (q.phase == PH_TSEG1 |-> q.len1 <= nom1 + sjw_len)
      else $error("Segment one lengthened beyond the jump width.");

   AST_SHORT_BOUND: assert property (q.phase == PH_TSEG2 |-> q.len2 + sjw_len >= nom2)
      else $error("Segment two shortened beyond the jump width.");

   AST_NOMINAL: assert property (q.evt.sample_point |-> q.len1 == nom1 && q.len2 == nom2)
      else $error("Segment lengths not nominal after sample point.");

   AST_SAMPLE_VALUE: assert property (q.evt.sample_point |-> q.evt.rx_bit == $past(q.rx_sync) && q.samp == q.evt.rx_bit)
      else $error("Sampled bit differs from bus level at sample point.");

   AST_EARLY_SKIP: assert property (q.evt.resync && q.phase == PH_TSEG1 && q.cnt == CNT_ZERO
                                    |-> $past(q.phase) == PH_TSEG2)
      else $error("Early edge did not skip the sync segment.");

   AST_SKIP_FULL: assert property (q.evt.resync && q.phase == PH_TSEG1 && $past(q.phase) == PH_TSEG2
                                   |-> q.len2 == $past(q.cnt))
      else $error("Sync segment skipped without full early correction.");

   COV_HARD: cover property (q.evt.hard_sync);
   COV_LATE: cover property (q.evt.resync && q.len1 > nom1);
   COV_EARLY: cover property (q.evt.resync && q.phase == PH_TSEG1 && $past(q.phase) == PH_TSEG2);
   COV_SAMPLE: cover property (q.evt.sample_point && q.evt.rx_bit == DOMINANT);

endmodule

`default_nettype wire

// file: bench/cbt_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module cbt_bus_model
   import cbt_pkg::*;
(
   // Node transmit request, high pulls the bus dominant
   input  wire logic dom_i,
   // Level seen by the receiver through the transceiver
   output logic      rx_o
);
   // The termination pulls the bus back to recessive as soon as no node drives it.
   assign rx_o = dom_i ? DOMINANT : RECESSIVE;
endmodule

`default_nettype wire

// file: bench/tb_can_bit_resync_logic.sv
`timescale 1ns/1ps
`default_nettype none

module tb_can_bit_resync_logic;
   import cbt_pkg::*;
   logic        ref_clk_i;
   logic        rst_n_i;
   logic        run_i;
   logic        hse;
   logic        dom;
   logic        rx;
   cbt_cfg_type cfg;
   cbt_evt_type evt;
   int          bad_count;
   int          checks;

   cbt_bus_model bus_u (.dom_i(dom), .rx_o(rx));
   cbt_bit_timing dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .run_i(run_i),
      .hard_sync_en_i(hse), .cfg_i(cfg), .rx_i(rx), .evt_o(evt));

   initial
   begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   task automatic summarize();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cmp_num(input int got, input int exp, input string msg);
      checks++;
      if (got != exp)
      begin
         bad_count++;
         $display("unexpected at %0t: %s got %0d want %0d", $time, msg, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp, input string msg);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: %s got %b want %b", $time, msg, got, exp);
      end
   endtask

   // Times are in clock periods; tr is the last resync or hard sync pulse.
   task automatic next_sp(output int t, output int nres, output int tr, output logic b);
      t = -1;
      nres = 0;
      tr = -1;
      b = 1'bx;
      for (int n = 0; n < 300 && t < 0; n++)
      begin
         @(posedge ref_clk_i);
         if (evt.resync === 1'b1)
            nres++;
         if (evt.resync === 1'b1 || evt.hard_sync === 1'b1)
            tr = int'($time / 4);
         if (evt.sample_point === 1'b1)
         begin
            t = int'($time / 4);
            b = evt.rx_bit;
         end
      end
      if (t < 0)
      begin
         bad_count++;
         $display("unexpected at %0t: no sample point", $time);
         summarize();
      end
   endtask

   // Configuration only changes while the timing is held idle.
   task automatic setup(input cbt_cfg_type c);
      int   t;
      int   n;
      int   tr;
      logic b;
      @(posedge ref_clk_i);
      run_i <= 1'b0;
      hse <= 1'b0;
      cfg <= c;
      repeat (2) @(posedge ref_clk_i);
      run_i <= 1'b1;
      next_sp(t, n, tr, b);
      next_sp(t, n, tr, b);
   endtask

   task automatic t_nominal();
      int   t0;
      int   t1;
      int   n;
      int   tr;
      logic b;
      setup('{6'h02, 4'h7, 3'h7, 2'h3});
      next_sp(t0, n, tr, b);
      next_sp(t1, n, tr, b);
      cmp_num(t1 - t0, 51, "bit length");
      cmp_num(n, 0, "idle resync");
      cmp_bit(b, RECESSIVE, "idle level");
      $display("test nominal done");
   endtask

   task automatic t_hard();
      int   t1;
      int   t2;
      int   n;
      int   tr;
      logic b;
      setup('{6'h00, 4'h7, 3'h7, 2'h3});
      @(posedge ref_clk_i);
      hse <= 1'b1;
      dom <= 1'b1;
      next_sp(t1, n, tr, b);
      cmp_num(t1 - tr, 8, "hard sync to sample");
      cmp_num(n, 0, "resync during hard sync");
      cmp_bit(b, DOMINANT, "hard sync level");
      @(posedge ref_clk_i);
      hse <= 1'b0;
      dom <= 1'b0;
      next_sp(t2, n, tr, b);
      cmp_num(t2 - t1, 17, "rising edge bit");
      cmp_num(n, 0, "rising edge resync");
      cmp_bit(b, RECESSIVE, "released level");
      $display("test hard sync done");
   endtask

   // Drives a dominant edge d clocks after a sample point; dur 0 holds it to the next one.
   task automatic edge_case(input int d, input int dur, input logic glitch, input logic rel,
                            input int exp, input logic eb);
      int   t0;
      int   t1;
      int   t2;
      int   n;
      int   tr;
      logic b;
      next_sp(t0, n, tr, b);
      fork
         begin
            repeat (d) @(posedge ref_clk_i);
            dom <= 1'b1;
            if (glitch)
            begin
               @(posedge ref_clk_i);
               dom <= 1'b0;
               repeat (2) @(posedge ref_clk_i);
               dom <= 1'b1;
            end
            if (dur > 0)
            begin
               repeat (dur) @(posedge ref_clk_i);
               dom <= 1'b0;
            end
         end
         next_sp(t1, n, tr, b);
      join
      cmp_num(n, 1, "resyncs in bit");
      cmp_num(rel ? t1 - tr : t1 - t0, exp, "sample distance");
      cmp_bit(b, eb, "sampled level");
      @(posedge ref_clk_i);
      dom <= 1'b0;
      next_sp(t2, n, tr, b);
      cmp_num(t2 - t1, 17, "following bit");
      cmp_num(n, 0, "release resync");
      $display("test edge d=%0d done", d);
   endtask

   task automatic t_late();
      setup('{6'h00, 4'h7, 3'h7, 2'h3});
      edge_case(7, 0, 1'b0, 1'b1, 8, DOMINANT);
   endtask

   task automatic t_spike();
      setup('{6'h00, 4'h7, 3'h7, 2'h3});
      edge_case(7, 8, 1'b0, 1'b1, 8, RECESSIVE);
   endtask

   task automatic t_early();
      setup('{6'h00, 4'h7, 3'h7, 2'h3});
      edge_case(2, 0, 1'b0, 1'b1, 8, DOMINANT);
   endtask

   task automatic t_early_long();
      setup('{6'h00, 4'h7, 3'h7, 2'h0});
      edge_case(0, 0, 1'b0, 1'b0, 16, DOMINANT);
   endtask

   // An error one quantum beyond the jump width must still keep the sync quantum.
   task automatic t_early_part();
      setup('{6'h00, 4'h7, 3'h7, 2'h0});
      edge_case(3, 0, 1'b0, 1'b0, 16, DOMINANT);
   endtask

   task automatic t_glitch();
      setup('{6'h00, 4'h7, 3'h7, 2'h1});
      edge_case(10, 0, 1'b1, 1'b0, 19, DOMINANT);
   endtask

   initial
   begin
      rst_n_i = 1'b0;
      run_i = 1'b0;
      hse = 1'b0;
      dom = 1'b0;
      cfg = '0;
      bad_count = 0;
      checks = 0;
      repeat (6) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      @(posedge ref_clk_i);
      cmp_bit(evt.rx_bit, RECESSIVE, "reset level");
      cmp_bit(evt.sample_point, 1'b0, "reset pulse");
      t_nominal();
      t_hard();
      t_late();
      t_spike();
      t_early();
      t_early_long();
      t_early_part();
      t_glitch();
      summarize();
   end
endmodule

`default_nettype wire
